// ### logic/dfbs_regs.svh
`ifndef DFBS_REGS_SVH
`define DFBS_REGS_SVH

// Bit positions of the three link lines within the output port.
`define DFBS_CS_BIT     0
`define DFBS_CLK_BIT    1
`define DFBS_DATA_BIT   2

// Number of bits in one frame, loaded into the bit counter.
`define DFBS_FRAME_BITS 5'h10

// Idle level of the port: select high, clock low, data low.
`define DFBS_PORT_IDLE  3'h1

`endif

// ### logic/dfbs_pkg.sv
`default_nettype none

package dfbs_pkg;

   // Link sequencer states; Gray steps along select, drive and rise.
   typedef enum logic [2:0]
   {
      DFBS_IDLE   = 3'h0,
      DFBS_SELECT = 3'h1,
      DFBS_DRIVE  = 3'h3,
      DFBS_RISE   = 3'h2,
      DFBS_FALL   = 3'h6,
      DFBS_FINISH = 3'h7
   } dfbs_state_e;

   typedef logic [4:0] dfbs_count_t;

endpackage : dfbs_pkg

`default_nettype wire

// ### logic/dfbs_sync.sv
`default_nettype none

// Two-flop synchroniser; only the second flop is visible outside.
module dfbs_sync
(
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic d,
   output var  logic q
);

   logic meta_reg;

   // The first flop may go metastable, so nothing but the second reads it.
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_reg <= 1'b0;
         q        <= 1'b0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule // dfbs_sync

`default_nettype wire

// ### logic/dfbs_sender.sv
`include "dfbs_regs.svh"
`default_nettype none

// Behaviour
// - Port bits 0,1,2 are select, clock, data.
// - Select goes low before any bit.
// - Bit counter loads sixteen per frame.
// - Data line follows address byte top bit.
// - One clock pulse, high then low, per bit.
// - Shift address then value left after pulse.
// - Count down; exactly sixteen bits per frame.
// - Address first, value second, MSB first.
// - Select returns high after sixteen bits.
module dfbs_sender
   import dfbs_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_b,
   input  wire logic       link_clock,
   input  wire logic       send_req,
   input  wire logic [7:0] send_addr,
   input  wire logic [7:0] send_value,
   output var  logic       send_ready,
   output var  logic       send_done,
   output var  logic       chip_select_b,
   output var  logic       bit_clock_pin,
   output var  logic       serial_data_pin
);

   logic        rst_sync_b;
   logic        link_rst_b;
   logic        ack_sync;
   logic        req_sync;

   // Main clock domain state.
   logic        ready_reg;
   logic        ready_next;
   logic        done_reg;
   logic        done_next;
   logic        req_tgl_reg;
   logic        req_tgl_next;
   logic        ack_seen_reg;
   logic        ack_seen_next;
   logic [7:0]  hold_addr_reg;
   logic [7:0]  hold_addr_next;
   logic [7:0]  hold_value_reg;
   logic [7:0]  hold_value_next;

   // Link clock domain state.
   dfbs_state_e state_reg;
   dfbs_state_e state_next;
   dfbs_count_t bit_count_reg;
   dfbs_count_t bit_count_next;
   logic [7:0]  addr_reg;
   logic [7:0]  addr_next;
   logic [7:0]  value_reg;
   logic [7:0]  value_next;
   logic [2:0]  port_reg;
   logic [2:0]  port_next;
   logic        req_seen_reg;
   logic        req_seen_next;
   logic        ack_tgl_reg;
   logic        ack_tgl_next;
   logic [4:0]  pulse_cnt_reg;
   logic [4:0]  pulse_cnt_next;

   // Reset release is synchronised separately into each domain.
   dfbs_sync u_rst_main
   (
      .clock (clock),
      .rst_b (rst_b),
      .d     (1'b1),
      .q     (rst_sync_b)
   );

   dfbs_sync u_rst_link
   (
      .clock (link_clock),
      .rst_b (rst_b),
      .d     (1'b1),
      .q     (link_rst_b)
   );

   // Request and acknowledge toggles cross as levels.
   dfbs_sync u_req_sync
   (
      .clock (link_clock),
      .rst_b (link_rst_b),
      .d     (req_tgl_reg),
      .q     (req_sync)
   );

   dfbs_sync u_ack_sync
   (
      .clock (clock),
      .rst_b (rst_sync_b),
      .d     (ack_tgl_reg),
      .q     (ack_sync)
   );

   // User side: the hold bytes stay frozen while a frame is in flight,
   // which is what makes it safe for the link domain to read them.
   always_comb
   begin
      ready_next      = ready_reg;
      done_next       = 1'b0;
      req_tgl_next    = req_tgl_reg;
      ack_seen_next   = ack_sync;
      hold_addr_next  = hold_addr_reg;
      hold_value_next = hold_value_reg;
      if (ready_reg && send_req)
      begin
         hold_addr_next  = send_addr;
         hold_value_next = send_value;
         req_tgl_next    = !req_tgl_reg;
         ready_next      = 1'b0;
      end
      else if (!ready_reg && (ack_sync != ack_seen_reg))
      begin
         ready_next = 1'b1;
         done_next  = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         ready_reg      <= 1'b1;
         done_reg       <= 1'b0;
         req_tgl_reg    <= 1'b0;
         ack_seen_reg   <= 1'b0;
         hold_addr_reg  <= 8'h00;
         hold_value_reg <= 8'h00;
      end
      else
      begin
         ready_reg      <= ready_next;
         done_reg       <= done_next;
         req_tgl_reg    <= req_tgl_next;
         ack_seen_reg   <= ack_seen_next;
         hold_addr_reg  <= hold_addr_next;
         hold_value_reg <= hold_value_next;
      end
   end

   // Handshake outputs come straight from their registers.
   assign send_ready = ready_reg;
   assign send_done  = done_reg;

   // Link sequencer: one link cycle of data setup before each rising
   // clock, so the converter samples a settled bit.
   always_comb
   begin
      state_next     = state_reg;
      bit_count_next = bit_count_reg;
      addr_next      = addr_reg;
      value_next     = value_reg;
      port_next      = port_reg;
      req_seen_next  = req_seen_reg;
      ack_tgl_next   = ack_tgl_reg;
      pulse_cnt_next = pulse_cnt_reg;
      unique case (state_reg)
         DFBS_IDLE:
         begin
            if (req_sync != req_seen_reg)
            begin
               req_seen_next           = req_sync;
               addr_next               = hold_addr_reg;
               value_next              = hold_value_reg;
               port_next[`DFBS_CS_BIT] = 1'b0;
               state_next              = DFBS_SELECT;
            end
         end
         DFBS_SELECT:
         begin
            bit_count_next = `DFBS_FRAME_BITS;
            pulse_cnt_next = 5'h00;
            state_next     = DFBS_DRIVE;
         end
         DFBS_DRIVE:
         begin
            port_next[`DFBS_DATA_BIT] = addr_reg[7];
            state_next                = DFBS_RISE;
         end
         DFBS_RISE:
         begin
            port_next[`DFBS_CLK_BIT] = 1'b1;
            pulse_cnt_next           = pulse_cnt_reg + 5'h01;
            state_next               = DFBS_FALL;
         end
         DFBS_FALL:
         begin
            port_next[`DFBS_CLK_BIT] = 1'b0;
            value_next     = {value_reg[6:0], 1'b0};
            addr_next      = {addr_reg[6:0], value_reg[7]};
            bit_count_next = bit_count_reg - 5'h01;
            state_next     = (bit_count_reg == 5'h01) ? DFBS_FINISH
                                                      : DFBS_DRIVE;
         end
         DFBS_FINISH:
         begin
            port_next[`DFBS_CS_BIT] = 1'b1;
            ack_tgl_next            = !ack_tgl_reg;
            state_next              = DFBS_IDLE;
         end
         default:
         begin
            port_next  = `DFBS_PORT_IDLE;
            state_next = DFBS_IDLE;
         end
      endcase
   end

   always_ff @(posedge link_clock or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         state_reg     <= DFBS_IDLE;
         bit_count_reg <= 5'h00;
         addr_reg      <= 8'h00;
         value_reg     <= 8'h00;
         port_reg      <= `DFBS_PORT_IDLE;
         req_seen_reg  <= 1'b0;
         ack_tgl_reg   <= 1'b0;
         pulse_cnt_reg <= 5'h00;
      end
      else
      begin
         state_reg     <= state_next;
         bit_count_reg <= bit_count_next;
         addr_reg      <= addr_next;
         value_reg     <= value_next;
         port_reg      <= port_next;
         req_seen_reg  <= req_seen_next;
         ack_tgl_reg   <= ack_tgl_next;
         pulse_cnt_reg <= pulse_cnt_next;
      end
   end

   // Pins come straight from the port register, so they never glitch.
   assign chip_select_b   = port_reg[`DFBS_CS_BIT];
   assign bit_clock_pin   = port_reg[`DFBS_CLK_BIT];
   assign serial_data_pin = port_reg[`DFBS_DATA_BIT];

   // Helper for the checks: the frame word as it should look one shift on.
   logic [15:0] shift_word;
   logic [15:0] shifted_word;

   assign shift_word   = {addr_reg, value_reg};
   assign shifted_word = {shift_word[14:0], 1'b0};

   // Checks on the link side.
   select_first_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      $rose(bit_clock_pin) |-> !chip_select_b)
      else $error("Clock rose while select was high.");
   count_load_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      state_reg == DFBS_SELECT |=> bit_count_reg == `DFBS_FRAME_BITS)
      else $error("Bit counter not loaded with sixteen.");

   data_bit_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      $rose(bit_clock_pin) |-> serial_data_pin == addr_reg[7])
      else $error("Data line does not match address top bit.");
   clock_pulse_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      $rose(bit_clock_pin) |=> $fell(bit_clock_pin))
      else $error("Clock pulse not one link cycle wide.");
   shift_step_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      state_reg == DFBS_FALL |=> shift_word == $past(shifted_word))
      else $error("Frame bytes did not shift left by one.");

   count_down_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      state_reg == DFBS_FALL
      |=> bit_count_reg == $past(bit_count_reg) - 5'h01)
      else $error("Bit counter did not step down by one.");
   sixteen_pulses_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      $rose(chip_select_b) |-> pulse_cnt_reg == `DFBS_FRAME_BITS)
      else $error("Frame did not carry sixteen clock pulses.");

   select_release_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      state_reg == DFBS_FALL && bit_count_reg == 5'h01
      |=> ##1 chip_select_b && !bit_clock_pin)
      else $error("Select not released after the last bit.");
   idle_quiet_a: assert property (
      @(posedge link_clock) disable iff (!link_rst_b)
      state_reg == DFBS_IDLE |-> chip_select_b && !bit_clock_pin)
      else $error("Idle link not quiet.");

endmodule // dfbs_sender

`default_nettype wire

// ### verif/dfbs_dac_model.sv
`default_nettype none

// Receiving converter: shifts the data line in on each rising serial clock
// while selected, and latches the frame when select rises again.
module dfbs_dac_model
(
   input  wire logic        chip_select_b,
   input  wire logic        bit_clock_pin,
   input  wire logic        serial_data_pin,
   output var  logic [15:0] got_frame,
   output var  int          got_bits,
   output var  int          frame_cnt,
   output var  int          stray_rise
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] shift_reg;
   int          n;
   bit          in_frame;

   initial
   begin
      got_frame = 16'h0000;
      got_bits = 0;
      frame_cnt = 0;
      stray_rise = 0;
      n = 0;
      in_frame = 0;
   end

   // A rise seen while deselected would corrupt the shift register.
   always @(posedge bit_clock_pin)
   begin
      if (chip_select_b === 1'b0)
      begin
         shift_reg = {shift_reg[14:0], serial_data_pin};
         n++;
      end
      else
         stray_rise++;
   end

   // Start of frame clears the bit count.
   always @(negedge chip_select_b)
   begin
      n = 0;
      in_frame = 1;
   end

   // Only a rise that closes a frame latches, not the power-up edge.
   always @(posedge chip_select_b)
   begin
      if (in_frame)
      begin
         got_frame = shift_reg;
         got_bits = n;
         frame_cnt++;
         in_frame = 0;
      end
   end
endmodule // dfbs_dac_model

`default_nettype wire

// ### verif/tb_top.sv
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clock = 0;
   logic        link_clock = 0;
   logic        rst_b = 1'b1;
   logic        send_req = 0;
   logic [7:0]  send_addr = 8'h00;
   logic [7:0]  send_value = 8'h00;
   logic        send_ready;
   logic        send_done;
   logic        chip_select_b;
   logic        bit_clock_pin;
   logic        serial_data_pin;
   logic [15:0] got_frame;
   int          got_bits;
   int          frame_cnt;
   int          stray_rise;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          n_sent = 0;
   int          exp_q[$];

   // System clock, 200 MHz.
   always #2.5 clock = ~clock;

   // Link clock, 125 ns, offset so its edges never meet the system clock.
   always
   begin
      if ($time == 0)
         #1.3;
      #62.5 link_clock = ~link_clock;
   end

   dfbs_sender u_dfbs_sender
   (
      .clock           (clock),
      .rst_b           (rst_b),
      .link_clock      (link_clock),
      .send_req        (send_req),
      .send_addr       (send_addr),
      .send_value      (send_value),
      .send_ready      (send_ready),
      .send_done       (send_done),
      .chip_select_b   (chip_select_b),
      .bit_clock_pin   (bit_clock_pin),
      .serial_data_pin (serial_data_pin)
   );

   dfbs_dac_model u_dfbs_dac_model
   (
      .chip_select_b   (chip_select_b),
      .bit_clock_pin   (bit_clock_pin),
      .serial_data_pin (serial_data_pin),
      .got_frame       (got_frame),
      .got_bits        (got_bits),
      .frame_cnt       (frame_cnt),
      .stray_rise      (stray_rise)
   );

   // Single comparison point; every check is counted.
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Called at a falling edge; poke raises a request while busy.
   task automatic send(logic [7:0] a, logic [7:0] v, bit poke);
      int i;
      while (send_ready !== 1'b1)
         @(negedge clock);
      send_addr = a;
      send_value = v;
      send_req = 1;
      exp_q.push_back({16'h0000, a, v});
      @(negedge clock);
      send_req = 0;
      if (poke)
      begin
         repeat (40) @(negedge clock);
         send_req = 1;
         @(negedge clock);
         send_req = 0;
      end
      i = 0;
      while (send_done !== 1'b1 && i < 20000)
      begin
         @(negedge clock);
         i++;
      end
      n_sent++;
      check("done", {31'h0, send_done}, 1);
      check("frames", frame_cnt, n_sent);
      check("frame", {16'h0, got_frame}, exp_q.pop_front());
      check("bits", got_bits, 16);
      check("select idle", {31'h0, chip_select_b}, 1);
      check("clock idle", {31'h0, bit_clock_pin}, 0);
      check("ready", {31'h0, send_ready}, 1);
   endtask

   // Hang guard, well beyond ten frames of about 1350 clocks each.
   initial
   begin
      repeat (60000) @(posedge clock);
      n_errors++;
      end_sim();
   end

   // Main sequence.
   initial
   begin
      void'($urandom(20));
      // Reset falls after time zero so the asynchronous resets see an edge;
      // a low level set at declaration would leave the link side unknown.
      @(negedge clock);
      rst_b = 1'b0;
      repeat (6) @(negedge clock);
      rst_b = 1'b1;
      repeat (3) @(posedge link_clock);
      @(negedge clock);
      send(8'h00, 8'h00, 0);
      send(8'hff, 8'hff, 0);
      send(8'h80, 8'h01, 0);
      $display("Test boundary frames done");
      send(8'ha5, 8'h5a, 1);
      $display("Test refused request done");
      repeat (6) send(8'($urandom), 8'($urandom), 1'b0);
      check("stray clocks", stray_rise, 0);
      $display("Test random frames done");
      end_sim();
   end
endmodule // tb_top

`default_nettype wire
